// ===== hdl/scan_tap.v
// Test access port controller with boundary, identification and bypass paths
`timescale 1ns/10ps
`default_nettype none
`include "scan_port_defines.vh"
module scan_tap #(
    parameter BSR_LEN = 96,
    parameter NPINS = 32,
    parameter [3:0] ID_VERSION = 4'h2,
    parameter [15:0] ID_PART = 16'h1234,
    parameter [10:0] ID_MFR = 11'h055,
    parameter [31:0] USER_CODE = 32'hFFFFFFFF
) (
    input wire mclk_in,
    input wire rst_n_in,
    input wire port_enable_in,
    input wire tck_in,
    input wire tms_in,
    input wire tdi_in,
    output reg tdo_out,
    output reg tdo_oe_out,
    output reg [3:0] user_pin_level_out,
    input wire user_tdo_in,
    input wire user_tdo_oe_in,
    input wire [NPINS-1:0] core_out_in,
    input wire [NPINS-1:0] core_oe_in,
    input wire [NPINS-1:0] pin_level_in,
    output reg [NPINS-1:0] pin_out,
    output reg [NPINS-1:0] pin_oe_out,
    output reg in_system_programming_out,
    output reg [`PROG_DATA_LEN-1:0] prog_word_out,
    output reg prog_word_valid_out
);
    // Note: ID parameter values are arbitrary
    // -----------------------------
    // Controller states
    // -----------------------------
    localparam [3:0] S_RESET = 4'h0, S_IDLE = 4'h1, S_SEL_DR = 4'h2, S_CAP_DR = 4'h3;
    localparam [3:0] S_SH_DR = 4'h4, S_EX1_DR = 4'h5, S_PA_DR = 4'h6, S_EX2_DR = 4'h7;
    localparam [3:0] S_UP_DR = 4'h8, S_SEL_IR = 4'h9, S_CAP_IR = 4'hA, S_SH_IR = 4'hB;
    localparam [3:0] S_EX1_IR = 4'hC, S_PA_IR = 4'hD, S_EX2_IR = 4'hE, S_UP_IR = 4'hF;
    localparam [2:0] P_BYP = 3'h0, P_ID = 3'h1, P_USR = 3'h2, P_BSR = 3'h3, P_PRG = 3'h4;
    localparam BSR_W = 3 * NPINS;

    wire [2:0] sync_level;
    wire [2:0] sync_rise;
    wire [2:0] sync_fall;
    wire tck_rise;
    wire tck_fall;
    wire tms_s;
    wire tdi_s;
    wire [NPINS-1:0] pin_level_s;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [`IR_LEN-1:0] ir_shift_reg;
    reg [`IR_LEN-1:0] ir_reg;
    reg [`ID_LEN-1:0] id_shift_reg;
    reg bypass_reg;
    reg [BSR_LEN-1:0] bsr_shift_reg;
    reg [BSR_LEN-1:0] bsr_update_reg;
    reg [`PROG_DATA_LEN-1:0] prog_shift_reg;
    reg [2:0] path;
    reg tdo_next;
    wire [BSR_LEN-1:0] bsr_capture;
    wire [`ID_LEN-1:0] id_word;
    wire extest_active;
    genvar g;

    // -----------------------------
    // Pin sampling
    // -----------------------------
    edge_sync #(
        .WIDTH(3)
    ) u_sync (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .async_in({tck_in, tms_in, tdi_in}),
        .level_out(sync_level),
        .rise_out(sync_rise),
        .fall_out(sync_fall)
    );
    assign tck_rise = sync_rise[2] & port_enable_in;
    assign tck_fall = sync_fall[2] & port_enable_in;
    assign tms_s = sync_level[1];
    assign tdi_s = sync_level[0];

    // Board pin levels cross into this clock before capture
    edge_sync #(
        .WIDTH(NPINS)
    ) u_pin_sync (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .async_in(pin_level_in),
        .level_out(pin_level_s),
        .rise_out(),
        .fall_out()
    );

    // -----------------------------
    // Decode
    // -----------------------------
    function [2:0] decode_path;
        input [`IR_LEN-1:0] op;
        begin
            case (op)
                `OP_EXTEST: decode_path = P_BSR;
                `OP_SAMPLE: decode_path = P_BSR;
                `OP_PART_IDENTIFICATION: decode_path = P_ID;
                `OP_USER_CODE_WORD: decode_path = P_USR;
                `OP_PROG_DATA: decode_path = P_PRG;
                default: decode_path = P_BYP;
            endcase
        end
    endfunction

    always @* begin
        path = decode_path(ir_reg);
    end

    // Identity word fields
    assign id_word[`ID_VERSION_MSB:`ID_VERSION_LSB] = ID_VERSION;
    assign id_word[`ID_PART_MSB:`ID_PART_LSB] = ID_PART;
    assign id_word[`ID_MFR_MSB:`ID_MFR_LSB] = ID_MFR;
    assign id_word[`ID_FIXED_BIT] = 1'b1;

    // Capture cells: per pin input, output, enable; rest read zero
    generate
        for (g = 0; g < BSR_LEN; g = g + 1) begin : g_cap
            if (g < BSR_W) begin : g_pin
                if (g % 3 == 0) begin : g_in
                    assign bsr_capture[g] = pin_level_s[g / 3];
                end else if (g % 3 == 1) begin : g_out
                    assign bsr_capture[g] = core_out_in[g / 3];
                end else begin : g_oe
                    assign bsr_capture[g] = core_oe_in[g / 3];
                end
            end else begin : g_pad
                assign bsr_capture[g] = 1'b0;
            end
        end
    endgenerate

    // -----------------------------
    // State machine
    // -----------------------------
    always @* begin
        case (state_reg)
            S_RESET: state_next = tms_s ? S_RESET : S_IDLE;
            S_IDLE: state_next = tms_s ? S_SEL_DR : S_IDLE;
            S_SEL_DR: state_next = tms_s ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: state_next = tms_s ? S_EX1_DR : S_SH_DR;
            S_SH_DR: state_next = tms_s ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: state_next = tms_s ? S_UP_DR : S_PA_DR;
            S_PA_DR: state_next = tms_s ? S_EX2_DR : S_PA_DR;
            S_EX2_DR: state_next = tms_s ? S_UP_DR : S_SH_DR;
            S_UP_DR: state_next = tms_s ? S_SEL_DR : S_IDLE;
            S_SEL_IR: state_next = tms_s ? S_RESET : S_CAP_IR;
            S_CAP_IR: state_next = tms_s ? S_EX1_IR : S_SH_IR;
            S_SH_IR: state_next = tms_s ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: state_next = tms_s ? S_UP_IR : S_PA_IR;
            S_PA_IR: state_next = tms_s ? S_EX2_IR : S_PA_IR;
            S_EX2_IR: state_next = tms_s ? S_UP_IR : S_SH_IR;
            S_UP_IR: state_next = tms_s ? S_SEL_DR : S_IDLE;
            default: state_next = S_RESET;
        endcase
    end

    // Serial output selection
    always @* begin
        if (state_reg == S_SH_IR) begin
            tdo_next = ir_shift_reg[0];
        end else begin
            case (path)
                P_ID: tdo_next = id_shift_reg[0];
                P_USR: tdo_next = id_shift_reg[0];
                P_BSR: tdo_next = bsr_shift_reg[0];
                P_PRG: tdo_next = prog_shift_reg[0];
                default: tdo_next = bypass_reg;
            endcase
        end
    end

    assign extest_active = (ir_reg == `OP_EXTEST);

    // -----------------------------
    // Scan registers, all stepped on rising test clock
    // -----------------------------
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= S_RESET;
            ir_shift_reg <= {`IR_LEN{1'b0}};
            ir_reg <= `OP_PART_IDENTIFICATION;
            id_shift_reg <= {`ID_LEN{1'b0}};
            bypass_reg <= 1'b0;
            bsr_shift_reg <= {BSR_LEN{1'b0}};
            bsr_update_reg <= {BSR_LEN{1'b0}};
            prog_shift_reg <= {`PROG_DATA_LEN{1'b0}};
            in_system_programming_out <= 1'b0;
            prog_word_out <= {`PROG_DATA_LEN{1'b0}};
            prog_word_valid_out <= 1'b0;
        end else begin
            prog_word_valid_out <= 1'b0;
            if (tck_rise) begin
                state_reg <= state_next;
                case (state_reg)
                    S_RESET: begin
                        ir_reg <= `OP_PART_IDENTIFICATION;
                        in_system_programming_out <= 1'b0;
                    end
                    S_CAP_IR: ir_shift_reg <= `IR_CAPTURE;
                    S_SH_IR: ir_shift_reg <= {tdi_s, ir_shift_reg[`IR_LEN-1:1]};
                    S_UP_IR: begin
                        ir_reg <= ir_shift_reg;
                        if (ir_shift_reg == `OP_PROG_ENTER) begin
                            in_system_programming_out <= 1'b1;
                        end else if (ir_shift_reg == `OP_PROG_EXIT) begin
                            in_system_programming_out <= 1'b0;
                        end
                    end
                    S_CAP_DR: begin
                        bypass_reg <= 1'b0;
                        if (path == P_ID) begin
                            id_shift_reg <= id_word;
                        end else if (path == P_USR) begin
                            id_shift_reg <= USER_CODE;
                        end
                        if (path == P_BSR) begin
                            bsr_shift_reg <= bsr_capture;
                        end
                    end
                    S_SH_DR: begin
                        case (path)
                            P_ID: id_shift_reg <= {tdi_s, id_shift_reg[`ID_LEN-1:1]};
                            P_USR: id_shift_reg <= {tdi_s, id_shift_reg[`ID_LEN-1:1]};
                            P_BSR: bsr_shift_reg <= {tdi_s, bsr_shift_reg[BSR_LEN-1:1]};
                            P_PRG: prog_shift_reg <= {tdi_s,
                                prog_shift_reg[`PROG_DATA_LEN-1:1]};
                            default: bypass_reg <= tdi_s;
                        endcase
                    end
                    S_UP_DR: begin
                        if (path == P_BSR) begin
                            bsr_update_reg <= bsr_shift_reg;
                        end
                        if (path == P_PRG && in_system_programming_out) begin
                            prog_word_out <= prog_shift_reg;
                            prog_word_valid_out <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // -----------------------------
    // Serial output on falling test clock while port enabled, user drive each system clock when off; pin drive updated on every system clock
    // -----------------------------
    integer i;
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
            user_pin_level_out <= 4'h0;
            pin_out <= {NPINS{1'b0}};
            pin_oe_out <= {NPINS{1'b0}};
        end else begin
            user_pin_level_out <= port_enable_in ? 4'h0 :
                {sync_level[2], sync_level[1], sync_level[0], 1'b0};
            if (!port_enable_in) begin
                tdo_out <= user_tdo_in;
                tdo_oe_out <= user_tdo_oe_in;
            end else if (tck_fall) begin
                tdo_out <= tdo_next;
                tdo_oe_out <= (state_reg == S_SH_DR) || (state_reg == S_SH_IR);
            end
            for (i = 0; i < NPINS; i = i + 1) begin
                if (in_system_programming_out) begin
                    pin_out[i] <= 1'b0;
                    pin_oe_out[i] <= 1'b0;
                end else if (extest_active && 3 * i + 2 < BSR_LEN) begin
                    pin_out[i] <= bsr_update_reg[3 * i + 1];
                    pin_oe_out[i] <= bsr_update_reg[3 * i + 2];
                end else begin
                    pin_out[i] <= core_out_in[i];
                    pin_oe_out[i] <= core_oe_in[i];
                end
            end
        end
    end
endmodule // scan_tap
`default_nettype wire

// ===== hdl/scan_port_defines.vh
// Constants for the test access port and boundary-scan block
`ifndef SCAN_PORT_DEFINES_VH
`define SCAN_PORT_DEFINES_VH
`define IR_LEN 10
`define ID_LEN 32
`define OP_EXTEST 10'h000
`define OP_SAMPLE 10'h055
`define OP_PART_IDENTIFICATION 10'h059
`define OP_USER_CODE_WORD 10'h079
`define OP_BYPASS 10'h3FF
`define OP_PROG_ENTER 10'h2CC
`define OP_PROG_EXIT 10'h201
`define OP_PROG_DATA 10'h2F3
`define IR_CAPTURE 10'h001
`define ID_VERSION_MSB 31
`define ID_VERSION_LSB 28
`define ID_PART_MSB 27
`define ID_PART_LSB 12
`define ID_MFR_MSB 11
`define ID_MFR_LSB 1
`define ID_FIXED_BIT 0
`define PROG_DATA_LEN 16
`endif

// ===== hdl/edge_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module edge_sync #(
    parameter WIDTH = 3
) (
    input wire mclk_in,
    input wire rst_n_in,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] level_out,
    output reg [WIDTH-1:0] rise_out,
    output reg [WIDTH-1:0] fall_out
);
    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    wire [WIDTH-1:0] agree;
    wire [WIDTH-1:0] level_next;
    assign agree = ~(s2_reg ^ s3_reg);
    assign level_next = (agree & s3_reg) | (~agree & level_out);
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_reg <= {WIDTH{1'b0}};
            s2_reg <= {WIDTH{1'b0}};
            s3_reg <= {WIDTH{1'b0}};
            level_out <= {WIDTH{1'b0}};
            rise_out <= {WIDTH{1'b0}};
            fall_out <= {WIDTH{1'b0}};
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_out <= level_next;
            rise_out <= level_next & ~level_out;
            fall_out <= ~level_next & level_out;
        end
    end
endmodule // edge_sync
`default_nettype wire

// ===== tb/scan_tap_checker.sv
// Assertion checker for the scan port block
`timescale 1ns/10ps
`default_nettype none
module scan_tap_checker #(
    parameter NPINS = 32
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic port_enable_in,
    input wire logic tck_in,
    input wire logic user_tdo_in,
    input wire logic tdo_out,
    input wire logic tdo_oe_out,
    input wire logic [3:0] user_pin_level_out,
    input wire logic [NPINS-1:0] pin_oe_out,
    input wire logic in_system_programming_out,
    input wire logic prog_word_valid_out
);
    logic [3:0] since_fall_reg;
    logic tck_last_reg;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);
    // Cycles since the raw test clock fell
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            since_fall_reg <= 4'hF;
            tck_last_reg <= 1'b0;
        end else begin
            tck_last_reg <= tck_in;
            if (tck_last_reg && !tck_in) begin
                since_fall_reg <= 4'h0;
            end else if (since_fall_reg != 4'hF) begin
                since_fall_reg <= since_fall_reg + 4'h1;
            end
        end
    end
    chk_tdo_after_fall: assert property (
        port_enable_in && $past(port_enable_in, 3) && $changed(tdo_out) |-> since_fall_reg < 4'h8)
        else $error("serial out moved away from a clock fall");
    chk_user_tdo_pass: assert property (
        !port_enable_in && !$past(port_enable_in) && $past(rst_n_in) |-> tdo_out == $past(user_tdo_in))
        else $error("serial out does not follow user drive");
    chk_levels_quiet: assert property (
        port_enable_in && $past(port_enable_in) |-> user_pin_level_out == 4'h0)
        else $error("pin levels shown while port active");
    chk_low_level_zero: assert property (user_pin_level_out[0] == 1'b0)
        else $error("lowest pin level bit set");
    chk_off_holds_mode: assert property (
        !port_enable_in && !$past(port_enable_in) |-> $stable(in_system_programming_out))
        else $error("programming mode moved while port off");
    chk_valid_single: assert property (prog_word_valid_out |=> !prog_word_valid_out)
        else $error("word strobe longer than one cycle");
    chk_prog_tristate: assert property (
        in_system_programming_out && $past(in_system_programming_out) |-> pin_oe_out == '0)
        else $error("pins driven in programming mode");
    chk_reset_quiet: assert property (
        $rose(rst_n_in) |-> !tdo_oe_out && !in_system_programming_out)
        else $error("outputs active after reset");
    cover property ($rose(in_system_programming_out));
    cover property (prog_word_valid_out);
    cover property ($rose(tdo_oe_out));
endmodule // scan_tap_checker
bind scan_tap scan_tap_checker #(.NPINS(NPINS)) u_scan_tap_checker (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .port_enable_in(port_enable_in),
    .tck_in(tck_in), .user_tdo_in(user_tdo_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
    .user_pin_level_out(user_pin_level_out), .pin_oe_out(pin_oe_out),
    .in_system_programming_out(in_system_programming_out),
    .prog_word_valid_out(prog_word_valid_out));
`default_nettype wire

// ===== tb/jtag_host.sv
// Test controller model for the scan port pins
`timescale 1ns/10ps
`default_nettype none
module jtag_host (
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    input wire logic tdo_in
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // One test clock; output read late as the port resynchronises
    task automatic step(input logic m, input logic b, output logic q);
        tms_out = m;
        tdi_out = b;
        #160 tck_out = 1'b1;
        #150 q = tdo_in;
        #10 tck_out = 1'b0;
    endtask
    task automatic tap_reset;
        logic q;
        for (int i = 0; i < 6; i++) step(i < 5, 1'b0, q);
    endtask
    task automatic hold(input logic [2:0] v);
        {tck_out, tms_out, tdi_out} = v;
    endtask
    // Scan from idle back to idle, low bit first
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
        output logic [127:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
endmodule // jtag_host
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the scan port block
`timescale 1ns/10ps
`default_nettype none
`include "scan_port_defines.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top;
    // Identity values are arbitrary
    localparam logic [31:0] ID_WORD = {4'h3, 16'hBEEF, 11'h2A5, 1'b1};
    localparam logic [31:0] UCODE = 32'h5A3C96E1;
    logic mclk_in, rst_n_in, en, utdo, uoe, tck, tms, tdi, tdo, tdo_oe, in_system_programming, pvalid;
    logic [3:0] upl;
    logic [15:0] pword;
    logic [31:0] core_out, core_oe, pin_lvl, pin_out, pin_oe;
    logic [127:0] d;
    int fail_count = 0;
    int checks_done = 0;
    int pulses = 0;
    scan_tap #(.BSR_LEN(96), .NPINS(32), .ID_VERSION(ID_WORD[31:28]), .ID_PART(ID_WORD[27:12]),
        .ID_MFR(ID_WORD[11:1]), .USER_CODE(UCODE)) u_scan_tap (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .port_enable_in(en), .tck_in(tck),
        .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
        .user_pin_level_out(upl), .user_tdo_in(utdo), .user_tdo_oe_in(uoe),
        .core_out_in(core_out), .core_oe_in(core_oe), .pin_level_in(pin_lvl),
        .pin_out(pin_out), .pin_oe_out(pin_oe), .in_system_programming_out(in_system_programming),
        .prog_word_out(pword), .prog_word_valid_out(pvalid));
    jtag_host u_jtag_host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo));
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        if (pvalid === 1'b1) pulses++;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic load(input logic [9:0] op);
        u_jtag_host.scan(1'b1, 20, {108'h0, op, 10'h2AA}, d);
        `CHK(d[9:0], `IR_CAPTURE)
        `CHK(d[19:10], 10'h2AA)
        `CHK(tdo_oe, 1'b0)
    endtask
    task automatic word_scan(input logic [31:0] w);
        u_jtag_host.scan(1'b0, 64, 128'h600DF00D, d);
        `CHK(d[31:0], w)
        `CHK(d[63:32], 32'h600DF00D)
    endtask
    task automatic t_id;
        u_jtag_host.tap_reset();
        word_scan(ID_WORD);
        `CHK(d[0], 1'b1)
        $display("test id done");
    endtask
    task automatic t_user;
        load(`OP_USER_CODE_WORD);
        word_scan(UCODE);
        $display("test user done");
    endtask
    task automatic t_bypass;
        for (int k = 0; k < 2; k++) begin
            load(k ? 10'h123 : `OP_BYPASS);
            u_jtag_host.scan(1'b0, 8, 128'hB5, d);
            `CHK(d[7:0], 8'h6A)
            `CHK(pin_out, core_out)
        end
        $display("test bypass done");
    endtask
    task automatic t_boundary;
        logic [127:0] exp, pre;
        logic [31:0] got;
        exp = '0;
        pre = '0;
        for (int i = 0; i < 32; i++) begin
            exp[3*i +: 3] = {core_oe[i], core_out[i], pin_lvl[i]};
            pre[3*i +: 3] = {i[0], ~i[1], 1'b0};
        end
        load(`OP_SAMPLE);
        u_jtag_host.scan(1'b0, 96, pre, d);
        `CHK(d[95:0], exp[95:0])
        `CHK({pin_oe, pin_out}, {core_oe, core_out})
        load(`OP_EXTEST);
        for (int i = 0; i < 32; i++) `CHK({pin_oe[i], pin_out[i]}, pre[3*i+1 +: 2])
        u_jtag_host.scan(1'b0, 104, 128'hC3, d);
        for (int i = 0; i < 32; i++) got[i] = d[3*i];
        `CHK(got, pin_lvl)
        `CHK(d[103:96], 8'hC3)
        $display("test boundary done");
    endtask
    task automatic t_isp;
        load(`OP_PROG_ENTER);
        `CHK({in_system_programming, pin_oe}, {1'b1, 32'h0})
        pulses = 0;
        load(`OP_PROG_DATA);
        u_jtag_host.scan(1'b0, 16, 128'hC35A, d);
        `CHK(pword, 16'hC35A)
        `CHK(pulses, 1)
        load(`OP_PROG_EXIT);
        `CHK(in_system_programming, 1'b0)
        $display("test programming done");
    endtask
    task automatic t_off;
        @(negedge mclk_in) en = 1'b0;
        for (int k = 0; k < 2; k++) begin
            @(negedge mclk_in) utdo = k[0];
            uoe = ~k[0];
            u_jtag_host.hold(k ? 3'b010 : 3'b101);
            repeat (8) @(negedge mclk_in);
            `CHK(upl, k ? 4'h4 : 4'hA)
            `CHK(tdo, k[0])
            `CHK(tdo_oe, ~k[0])
        end
        u_jtag_host.hold(3'b000);
        repeat (8) @(negedge mclk_in);
        en = 1'b1;
        $display("test port off done");
    endtask
    initial begin
        #1000000;
        fail_count++;
        test_done();
    end
    initial begin
        rst_n_in = 1'b0;
        en = 1'b1;
        utdo = 1'b0;
        uoe = 1'b0;
        core_out = 32'hF0F01234;
        core_oe = 32'h0F0FFFFF;
        pin_lvl = 32'hA5A5C3C3;
        repeat (5) @(posedge mclk_in);
        @(negedge mclk_in) rst_n_in = 1'b1;
        repeat (4) @(negedge mclk_in);
        t_id();
        t_user();
        t_bypass();
        t_boundary();
        t_isp();
        t_off();
        test_done();
    end
endmodule // tb_top
`default_nettype wire
